// >>> hw/spg_top.sv
// Overview of operation
// - Six-output mode when channel-A enable and upper mode bit are set.
// - All six pin waveforms come from the one channel-A waveform.
// - Override bit 0 shows port value; 1 lets compare output through.
// - Lower mode bit 0: count zero to top, then clear next tick.
// - Single slope: active level at match, opposite at wrap.
// - Single slope: overflow flag set when counter reaches top.
// - Lower mode bit 1 in six-output mode: count up to top, then down to zero.
// - Dual slope: switch one way on up match, other way down.
// - Dual slope: overflow flag set when counter reaches zero.
// - Pair field nonzero: true wave on even pin, inverted on odd.
// - Timer tick is only a count enable on the system clock.
// - Fault trigger clears pair fields and hands pins to port bits.
// - Fault trigger clears the guard enable in the same cycle.
// - Fault raises an interrupt when its interrupt enable is set.
// - Trigger source is the pin, or the comparator when selected.
// - Filter output changes only after four equal samples.
// - Filter enable inserts four system clocks of delay.
// - One shared two-bit high holding register for all wide registers.
// - Low byte write loads holding bits and byte together.
// - Low byte read copies upper bits into the holding register.
// - Single slope, field 01: clear at match, set at zero.
//
// The register addresses and the strobed register port were decided locally.
module spg_top (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	input wire logic timer_tick,
	input wire logic [5:0] port_value,
	input wire logic ext_irq_pin,
	input wire logic comparator_output,
	output logic [5:0] pwm_pin,
	output logic [5:0] pwm_drive,
	output logic overflow_irq,
	output logic fault_irq
);
	localparam int W = spg_pkg::CNT_W;

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	logic rst_meta;
	logic rst_n;

	// Release is delayed two clocks, assertion is immediate
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// ----------------------------------------------------------------
	// Software registers
	// ----------------------------------------------------------------
	logic [1:0] shared_high_bits;
	logic [W-1:0] compare_value_a;
	logic [W-1:0] compare_value_b;
	logic [W-1:0] compare_value_d;
	logic [W-1:0] top_value;
	logic pwm_enable_ch_a;
	logic waveform_mode_hi;
	logic waveform_mode_lo;
	logic [1:0] out_mode_pair_a;
	logic [1:0] out_mode_pair_b;
	logic [1:0] out_mode_pair_d;
	logic [5:0] override_enable_reg;
	logic fault_guard_enable;
	logic fault_irq_enable;
	logic fault_src_comparator;
	logic fault_filter_enable;
	logic [1:0] fault_edge_sel;
	logic overflow_flag;
	logic match_flag_a;
	logic fault_flag;
	logic overflow_irq_enable;
	logic waveform_out_a;
	logic [W-1:0] counter_value;
	logic count_up;
	logic hit_top;
	logic hit_zero;
	logic hit_match;

	// Address decode
	wire logic wr_count = wr & (addr == spg_pkg::OFS_COUNT);
	wire logic wr_cmp_a = wr & (addr == spg_pkg::OFS_CMP_A);
	wire logic wr_cmp_b = wr & (addr == spg_pkg::OFS_CMP_B);
	wire logic wr_top = wr & (addr == spg_pkg::OFS_TOP);
	wire logic wr_cmp_d = wr & (addr == spg_pkg::OFS_CMP_D);
	wire logic wr_high = wr & (addr == spg_pkg::OFS_HIGH);
	wire logic wr_ctrl_a = wr & (addr == spg_pkg::OFS_CTRL_A);
	wire logic wr_ctrl_b = wr & (addr == spg_pkg::OFS_CTRL_B);
	wire logic wr_ovr = wr & (addr == spg_pkg::OFS_OVERRIDE);
	wire logic wr_ctrl_d = wr & (addr == spg_pkg::OFS_CTRL_D);
	wire logic wr_flags = wr & (addr == spg_pkg::OFS_FLAGS);
	wire logic wr_irq_en = wr & (addr == spg_pkg::OFS_IRQ_EN);
	wire logic [W-1:0] wide_value = {shared_high_bits, wdata};

	// Mode decode
	wire logic six_mode = pwm_enable_ch_a & waveform_mode_hi;
	wire logic dual_slope = six_mode & waveform_mode_lo;
	wire logic fault_hit;
	wire logic fault_fire = fault_hit & fault_guard_enable;

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	logic [7:0] read_mux;
	logic [1:0] read_high;

	// Low-byte reads also pick the upper bits for the holding register
	always_comb begin
		read_mux = 8'h00;
		read_high = shared_high_bits;
		case (addr)
			spg_pkg::OFS_COUNT: begin
				read_mux = counter_value[7:0];
				read_high = counter_value[W-1:8];
			end
			spg_pkg::OFS_CMP_A: begin
				read_mux = compare_value_a[7:0];
				read_high = compare_value_a[W-1:8];
			end
			spg_pkg::OFS_CMP_B: begin
				read_mux = compare_value_b[7:0];
				read_high = compare_value_b[W-1:8];
			end
			spg_pkg::OFS_TOP: begin
				read_mux = top_value[7:0];
				read_high = top_value[W-1:8];
			end
			spg_pkg::OFS_CMP_D: begin
				read_mux = compare_value_d[7:0];
				read_high = compare_value_d[W-1:8];
			end
			spg_pkg::OFS_HIGH: read_mux = {6'h00, shared_high_bits};
			spg_pkg::OFS_CTRL_A: read_mux = {2'h0, out_mode_pair_a, 1'b0,
				waveform_mode_lo, waveform_mode_hi, pwm_enable_ch_a};
			spg_pkg::OFS_CTRL_B: read_mux = {4'h0, out_mode_pair_d,
				out_mode_pair_b};
			spg_pkg::OFS_OVERRIDE: read_mux = {2'h0, override_enable_reg};
			spg_pkg::OFS_CTRL_D: read_mux = {2'h0, fault_edge_sel,
				fault_filter_enable, fault_src_comparator,
				fault_irq_enable, fault_guard_enable};
			spg_pkg::OFS_FLAGS: read_mux = {5'h00, fault_flag,
				match_flag_a, overflow_flag};
			spg_pkg::OFS_IRQ_EN: read_mux = {7'h00, overflow_irq_enable};
			default: read_mux = 8'h00;
		endcase
	end

	// Data stand in the cycle after the strobe only
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= 8'h00;
		end else begin
			rdata <= rd ? read_mux : 8'h00;
		end
	end

	// ----------------------------------------------------------------
	// Holding register and wide registers
	// ----------------------------------------------------------------
	// One holding register serves every wide register, so an access
	// interrupted by another wide access corrupts the first one
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			shared_high_bits <= 2'h0;
		end else if (wr_high) begin
			shared_high_bits <= wdata[1:0];
		end else if (rd) begin
			shared_high_bits <= read_high;
		end
	end

	// Compare and top registers load all ten bits at the low write
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			compare_value_a <= '0;
			compare_value_b <= '0;
			compare_value_d <= '0;
			top_value <= spg_pkg::TOP_RESET;
		end else begin
			if (wr_cmp_a) compare_value_a <= wide_value;
			if (wr_cmp_b) compare_value_b <= wide_value;
			if (wr_cmp_d) compare_value_d <= wide_value;
			if (wr_top) top_value <= wide_value;
		end
	end

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	// A fault in the same cycle as a software write wins, so a write
	// cannot reconnect the pins behind the guard's back
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pwm_enable_ch_a <= 1'b0;
			waveform_mode_hi <= 1'b0;
			waveform_mode_lo <= 1'b0;
			out_mode_pair_a <= 2'h0;
			out_mode_pair_b <= 2'h0;
			out_mode_pair_d <= 2'h0;
		end else begin
			if (wr_ctrl_a) begin
				pwm_enable_ch_a <= wdata[spg_pkg::BIT_PWM_EN];
				waveform_mode_hi <= wdata[spg_pkg::BIT_MODE_HI];
				waveform_mode_lo <= wdata[spg_pkg::BIT_MODE_LO];
				out_mode_pair_a <= wdata[spg_pkg::POS_PAIR_A+:2];
			end
			if (wr_ctrl_b) begin
				out_mode_pair_b <= wdata[spg_pkg::POS_PAIR_B+:2];
				out_mode_pair_d <= wdata[spg_pkg::POS_PAIR_D+:2];
			end
			if (fault_fire) begin
				out_mode_pair_a <= 2'h0;
				out_mode_pair_b <= 2'h0;
				out_mode_pair_d <= 2'h0;
			end
		end
	end

	// Guard setup; the enable drops together with the pair fields
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			override_enable_reg <= 6'h00;
			fault_guard_enable <= 1'b0;
			fault_irq_enable <= 1'b0;
			fault_src_comparator <= 1'b0;
			fault_filter_enable <= 1'b0;
			fault_edge_sel <= 2'h0;
			overflow_irq_enable <= 1'b0;
		end else begin
			if (wr_ovr) override_enable_reg <= wdata[5:0];
			if (wr_irq_en) overflow_irq_enable <= wdata[0];
			if (wr_ctrl_d) begin
				fault_guard_enable <= wdata[spg_pkg::BIT_FG_EN];
				fault_irq_enable <= wdata[spg_pkg::BIT_FG_IRQ];
				fault_src_comparator <= wdata[spg_pkg::BIT_FG_COMP];
				fault_filter_enable <= wdata[spg_pkg::BIT_FG_FILT];
				fault_edge_sel <= wdata[spg_pkg::POS_FG_EDGE+:2];
			end
			if (fault_fire) fault_guard_enable <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Counter and fault guard
	// ----------------------------------------------------------------
	spg_fault_if fbus ();
	assign fbus.ext_pin = ext_irq_pin;
	assign fbus.comp_out = comparator_output;
	assign fbus.src_comp = fault_src_comparator;
	assign fbus.filter_en = fault_filter_enable;
	assign fbus.edge_sel = fault_edge_sel;
	assign fault_hit = fbus.trigger;

	spg_fault_guard u_guard (
		.clk(clk),
		.rst_n(rst_n),
		.fb(fbus.guard)
	);

	spg_counter #(
		.W(W)
	) u_counter (
		.clk(clk),
		.rst_n(rst_n),
		.tick(timer_tick),
		.dual(dual_slope),
		.load(wr_count),
		.load_value(wide_value),
		.top(top_value),
		.cmp(compare_value_a),
		.count(counter_value),
		.up(count_up),
		.hit_top(hit_top),
		.hit_zero(hit_zero),
		.hit_match(hit_match)
	);

	// ----------------------------------------------------------------
	// Waveform and flags
	// ----------------------------------------------------------------
	// Field 11 sets at match; 01 and 10 clear at match
	wire logic match_level = &out_mode_pair_a;
	wire logic ovf_event = dual_slope ? hit_zero : hit_top;
	wire logic flag_clr_ovf = wr_flags & wdata[spg_pkg::BIT_OVF];
	wire logic flag_clr_match = wr_flags & wdata[spg_pkg::BIT_MATCH];
	wire logic flag_clr_fault = wr_flags & wdata[spg_pkg::BIT_FAULT];

	// Match has priority over the zero edge when compare is zero
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			waveform_out_a <= 1'b0;
		end else if (hit_match) begin
			waveform_out_a <= (count_up | ~dual_slope) ? match_level :
				~match_level;
		end else if (hit_zero & ~dual_slope) begin
			waveform_out_a <= ~match_level;
		end
	end

	// Set beats a clear written in the same cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			overflow_flag <= 1'b0;
			match_flag_a <= 1'b0;
			fault_flag <= 1'b0;
			overflow_irq <= 1'b0;
			fault_irq <= 1'b0;
		end else begin
			overflow_flag <= (overflow_flag & ~flag_clr_ovf) | ovf_event;
			match_flag_a <= (match_flag_a & ~flag_clr_match) | hit_match;
			fault_flag <= (fault_flag & ~flag_clr_fault) | fault_fire;
			overflow_irq <= overflow_flag & overflow_irq_enable;
			fault_irq <= fault_flag & fault_irq_enable;
		end
	end

	// ----------------------------------------------------------------
	// Pin steering
	// ----------------------------------------------------------------
	wire logic [5:0] pair_fields = {out_mode_pair_d, out_mode_pair_b,
		out_mode_pair_a};
	logic [5:0] next_pin;
	logic [5:0] next_drive;

	// Both pins of a pair follow the one channel-A waveform
	for (genvar p = 0; p < spg_pkg::PAIRS; p++) begin : g_pair
		wire logic on = six_mode & |pair_fields[2*p+:2];
		assign next_drive[2*p] = on & override_enable_reg[2*p];
		assign next_drive[2*p+1] = on & override_enable_reg[2*p+1];
		assign next_pin[2*p] = next_drive[2*p] ? waveform_out_a :
			port_value[2*p];
		assign next_pin[2*p+1] = next_drive[2*p+1] ? ~waveform_out_a :
			port_value[2*p+1];
	end

	// Pins are registered, so override changes show one clock later
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pwm_pin <= 6'h00;
			pwm_drive <= 6'h00;
		end else begin
			pwm_pin <= next_pin;
			pwm_drive <= next_drive;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	AST_MODE_ENTRY: assert property (@(posedge clk) disable iff (!rst_n)
		(!pwm_enable_ch_a | !waveform_mode_hi) |=> pwm_drive == 6'h00)
		else $error("pins driven outside six-output mode");
	AST_PORT_PASS: assert property (@(posedge clk) disable iff (!rst_n)
		!override_enable_reg[0] |=> pwm_pin[0] == $past(port_value[0]))
		else $error("pin 0 not showing port value");
	AST_COMPLEMENT: assert property (@(posedge clk) disable iff (!rst_n)
		&next_drive[1:0] |=> pwm_pin[0] != pwm_pin[1])
		else $error("pair A pins not complementary");
	AST_WRAP: assert property (@(posedge clk) disable iff (!rst_n)
		timer_tick && !dual_slope && !wr_count && counter_value == top_value
		|=> counter_value == 10'h000)
		else $error("single slope did not clear after top");
	AST_TURN: assert property (@(posedge clk) disable iff (!rst_n)
		timer_tick && dual_slope && count_up && !wr_count &&
		counter_value == top_value && top_value != 10'h000
		|=> !count_up ##0 counter_value == $past(top_value) - 10'h001)
		else $error("dual slope did not turn at top");
	AST_OVF_TOP: assert property (@(posedge clk) disable iff (!rst_n)
		hit_top && !dual_slope |=> overflow_flag)
		else $error("overflow flag missed at top");
	AST_OVF_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
		hit_zero && dual_slope |=> overflow_flag)
		else $error("overflow flag missed at zero");
	AST_WAVE_SET: assert property (@(posedge clk) disable iff (!rst_n)
		hit_zero && !hit_match && !dual_slope && out_mode_pair_a == 2'h1
		|=> waveform_out_a)
		else $error("waveform not set at zero");
	AST_FAULT_CUT: assert property (@(posedge clk) disable iff (!rst_n)
		fault_fire |=> pair_fields == 6'h00 && !fault_guard_enable
		##1 pwm_drive == 6'h00)
		else $error("fault did not disconnect pins");
	AST_FAULT_IRQ: assert property (@(posedge clk) disable iff (!rst_n)
		fault_fire && fault_irq_enable && !wr_ctrl_d |-> ##2 fault_irq)
		else $error("fault interrupt missing");
	AST_WIDE_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
		wr_cmp_a |=> compare_value_a ==
		{$past(shared_high_bits), $past(wdata)})
		else $error("wide write lost the held bits");
	AST_WIDE_READ: assert property (@(posedge clk) disable iff (!rst_n)
		rd && addr == spg_pkg::OFS_TOP |=>
		shared_high_bits == $past(top_value[9:8]))
		else $error("low read did not capture high bits");

	COV_FAULT: cover property (@(posedge clk) disable iff (!rst_n)
		fault_fire ##1 fault_flag);
	COV_TURN: cover property (@(posedge clk) disable iff (!rst_n)
		dual_slope && $fell(count_up));
	COV_WRAP: cover property (@(posedge clk) disable iff (!rst_n)
		six_mode && !dual_slope && hit_match ##[1:100] hit_zero);
endmodule : spg_top

// >>> hw/spg_pkg.sv
package spg_pkg;
	// ----------------------------------------------------------------
	// Widths and counts
	// ----------------------------------------------------------------
	localparam int CNT_W = 10;
	localparam int FILTER_LEN = 4;
	localparam int PAIRS = 3;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [3:0] OFS_COUNT = 4'h0;
	localparam logic [3:0] OFS_CMP_A = 4'h1;
	localparam logic [3:0] OFS_CMP_B = 4'h2;
	localparam logic [3:0] OFS_TOP = 4'h3;
	localparam logic [3:0] OFS_CMP_D = 4'h4;
	localparam logic [3:0] OFS_HIGH = 4'h5;
	localparam logic [3:0] OFS_CTRL_A = 4'h6;
	localparam logic [3:0] OFS_CTRL_B = 4'h7;
	localparam logic [3:0] OFS_OVERRIDE = 4'h8;
	localparam logic [3:0] OFS_CTRL_D = 4'h9;
	localparam logic [3:0] OFS_FLAGS = 4'hA;
	localparam logic [3:0] OFS_IRQ_EN = 4'hB;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int BIT_PWM_EN = 0;
	localparam int BIT_MODE_HI = 1;
	localparam int BIT_MODE_LO = 2;
	localparam int POS_PAIR_A = 4;
	localparam int POS_PAIR_B = 0;
	localparam int POS_PAIR_D = 2;
	localparam int BIT_FG_EN = 0;
	localparam int BIT_FG_IRQ = 1;
	localparam int BIT_FG_COMP = 2;
	localparam int BIT_FG_FILT = 3;
	localparam int POS_FG_EDGE = 4;
	localparam int BIT_OVF = 0;
	localparam int BIT_MATCH = 1;
	localparam int BIT_FAULT = 2;

	// ----------------------------------------------------------------
	// Edge codes and reset values
	// ----------------------------------------------------------------
	localparam logic [1:0] EDGE_FALL = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [9:0] TOP_RESET = 10'h3FF;
endpackage : spg_pkg

// >>> hw/spg_fault_if.sv
interface spg_fault_if;
	logic ext_pin;
	logic comp_out;
	logic src_comp;
	logic filter_en;
	logic [1:0] edge_sel;
	logic trigger;
	modport guard(input ext_pin, comp_out, src_comp, filter_en, edge_sel,
		output trigger);
	modport core(output ext_pin, comp_out, src_comp, filter_en, edge_sel,
		input trigger);
endinterface : spg_fault_if

// >>> hw/spg_fault_guard.sv
module spg_fault_guard (
	input wire logic clk,
	input wire logic rst_n,
	spg_fault_if.guard fb
);
	logic [spg_pkg::FILTER_LEN-1:0] samples;
	logic filt;
	logic prev;
	wire logic source = fb.src_comp ? fb.comp_out : fb.ext_pin;
	wire logic all_one = &samples;
	wire logic all_zero = ~|samples;
	wire logic chosen = fb.filter_en ? filt : samples[0];
	wire logic rise = chosen & ~prev;
	wire logic fall = ~chosen & prev;

	// ----------------------------------------------------------------
	// Sampling, filter and edge detector
	// ----------------------------------------------------------------
	// Filter runs every system clock, prescaler plays no part
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			samples <= '0;
			filt <= 1'b0;
			prev <= 1'b0;
		end else begin
			samples <= {samples[spg_pkg::FILTER_LEN-2:0], source};
			if (all_one | all_zero) begin
				filt <= samples[0];
			end
			prev <= chosen;
		end
	end

	// Either-edge codes share the default arm
	assign fb.trigger = (fb.edge_sel == spg_pkg::EDGE_FALL) ? fall :
		(fb.edge_sel == spg_pkg::EDGE_RISE) ? rise : (rise | fall);

	AST_FILTER_AGREE: assert property (@(posedge clk) disable iff (!rst_n)
		$changed(filt) |-> ($past(all_one) | $past(all_zero)))
		else $error("filter output moved without four equal samples");
endmodule : spg_fault_guard

// >>> hw/spg_counter.sv
module spg_counter #(
	parameter int W = 10
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic tick,
	input wire logic dual,
	input wire logic load,
	input wire logic [W-1:0] load_value,
	input wire logic [W-1:0] top,
	input wire logic [W-1:0] cmp,
	output logic [W-1:0] count,
	output logic up,
	output logic hit_top,
	output logic hit_zero,
	output logic hit_match
);
	logic [W-1:0] next_count;
	logic next_up;
	wire logic at_max = (count == top);
	wire logic at_min = (count == '0);

	// Next count: wrap for single slope, turn round for dual slope
	always_comb begin
		next_up = 1'b1;
		next_count = at_max ? '0 : count + 1'b1;
		if (dual) begin
			next_up = up ? ~at_max : at_min;
			if (at_max & at_min) begin
				next_count = '0;
			end else if (next_up) begin
				next_count = count + 1'b1;
			end else begin
				next_count = count - 1'b1;
			end
		end
	end

	// Event pulses stand in the cycle where count shows the new value
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= '0;
			up <= 1'b1;
			hit_top <= 1'b0;
			hit_zero <= 1'b0;
			hit_match <= 1'b0;
		end else begin
			hit_top <= tick & ~load & (next_count == top);
			hit_zero <= tick & ~load & (next_count == '0);
			hit_match <= tick & ~load & (next_count == cmp);
			if (load) begin
				count <= load_value;
			end else if (tick) begin
				count <= next_count;
				up <= next_up;
			end
		end
	end
endmodule : spg_counter

// >>> testbench/spg_stage_model.sv
// ----------------------------------------------------------------
// Power stage sense lines seen by the fault guard
// ----------------------------------------------------------------
module spg_stage_model (
	input wire logic clk,
	input wire logic trip_pin,
	input wire logic trip_comp,
	output logic ext_irq_pin,
	output logic comparator_output
);
	timeunit 1ns;
	timeprecision 1ps;
	// Overcurrent sense is a plain logic line
	assign ext_irq_pin = trip_pin;
	// Comparator settles a cycle late, like a real analog path
	initial comparator_output = 1'b0;
	always @(posedge clk) begin
		comparator_output <= trip_comp;
	end
endmodule : spg_stage_model

// >>> testbench/six_output_pwm_fault_guard_tb.sv
module six_output_pwm_fault_guard_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic run = 1'b0;
	logic timer_tick = 1'b0;
	logic trip_pin = 1'b0;
	logic trip_comp = 1'b0;
	logic ext_irq_pin, comparator_output, overflow_irq, fault_irq;
	logic [7:0] rdata, v;
	logic [5:0] pwm_pin, pwm_drive;
	logic [7:0] mode [2] = '{8'h23, 8'h27};
	logic [7:0] cfg [3] = '{8'h13, 8'h15, 8'h19};
	int miscompares = 0;
	int tests_run = 0;

	initial forever #2.5 clk = ~clk;
	// Half-rate count enable keeps the tick a true enable, not a clock
	always @(posedge clk) timer_tick <= run & ~timer_tick;

	spg_stage_model PART (.clk(clk), .trip_pin(trip_pin),
		.trip_comp(trip_comp), .ext_irq_pin(ext_irq_pin),
		.comparator_output(comparator_output));
	spg_top DUT (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .timer_tick(timer_tick),
		.port_value(6'h15), .ext_irq_pin(ext_irq_pin),
		.comparator_output(comparator_output), .pwm_pin(pwm_pin),
		.pwm_drive(pwm_drive), .overflow_irq(overflow_irq),
		.fault_irq(fault_irq));

	// ----------------------------------------------------------------
	// Bus and check tasks
	// ----------------------------------------------------------------
	task test_done;
		if (miscompares == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : test_done
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %0t seen %h want %h", $time, seen, exp);
		end
	endtask : chk
	task wreg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wreg
	// Read data stands only in the cycle after the strobe
	task rreg(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : rreg
	task wdrv(input logic [5:0] want);
		int n;
		n = 0;
		while (pwm_drive !== want) begin
			if (n == 60) begin
				miscompares++;
				test_done();
			end
			n++;
			@(posedge clk);
			#1;
		end
	endtask : wdrv

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		wreg(spg_pkg::OFS_HIGH, 8'h01);
		wreg(spg_pkg::OFS_COUNT, 8'hFF);
		rreg(spg_pkg::OFS_TOP, v); chk(v, 8'hFF);
		rreg(spg_pkg::OFS_HIGH, v); chk(v, 8'h03);
		rreg(spg_pkg::OFS_COUNT, v); chk(v, 8'hFF);
		rreg(spg_pkg::OFS_HIGH, v); chk(v, 8'h01);
		rreg(4'hF, v); chk(v, 8'h00);
		// Short period so both slopes wrap many times
		wreg(spg_pkg::OFS_HIGH, 8'h00);
		// Restart from zero, else the count climbs past top to 0x3FF
		wreg(spg_pkg::OFS_COUNT, 8'h00);
		wreg(spg_pkg::OFS_CMP_A, 8'h01);
		wreg(spg_pkg::OFS_TOP, 8'h03);
		wreg(spg_pkg::OFS_CTRL_B, 8'h05);
		wreg(spg_pkg::OFS_OVERRIDE, 8'h3E);
		wreg(spg_pkg::OFS_IRQ_EN, 8'h01);
		foreach (mode[i]) begin
			wreg(spg_pkg::OFS_CTRL_A, mode[i]);
			run <= 1'b1;
			wreg(spg_pkg::OFS_FLAGS, 8'h07);
			repeat (20) @(posedge clk);
			rreg(spg_pkg::OFS_FLAGS, v); chk(v & 8'h01, 8'h01);
			chk({7'h0, overflow_irq}, 8'h01);
			chk({2'h0, pwm_drive}, 8'h3E);
			chk({7'h0, pwm_pin[0]}, 8'h01);
			chk({7'h0, pwm_pin[2] ^ pwm_pin[3]}, 8'h01);
			chk({7'h0, pwm_pin[2] ^ pwm_pin[4]}, 8'h00);
		end
		wreg(spg_pkg::OFS_OVERRIDE, 8'h3F);
		foreach (cfg[i]) begin
			trip_pin <= 1'b0;
			trip_comp <= 1'b0;
			repeat (12) @(posedge clk);
			// A fault clears every pair field, so restore all three
			wreg(spg_pkg::OFS_CTRL_A, 8'h23);
			wreg(spg_pkg::OFS_CTRL_B, 8'h05);
			wreg(spg_pkg::OFS_CTRL_D, cfg[i]);
			wreg(spg_pkg::OFS_FLAGS, 8'h07);
			wdrv(6'h3F);
			if (cfg[i][3]) begin
				// Two-cycle spike must not get through the filter
				trip_pin <= 1'b1;
				repeat (2) @(posedge clk);
				trip_pin <= 1'b0;
				repeat (14) @(posedge clk);
				chk({2'h0, pwm_drive}, 8'h3F);
			end
			if (cfg[i][2])
				trip_comp <= 1'b1;
			else
				trip_pin <= 1'b1;
			wdrv(6'h00);
			rreg(spg_pkg::OFS_CTRL_D, v); chk(v, cfg[i] & 8'hFE);
			rreg(spg_pkg::OFS_CTRL_A, v); chk(v, 8'h03);
			rreg(spg_pkg::OFS_FLAGS, v); chk(v & 8'h04, 8'h04);
			chk({7'h0, fault_irq}, {7'h0, cfg[i][1]});
			chk({2'h0, pwm_pin}, 8'h15);
		end
		test_done();
	end
endmodule : six_output_pwm_fault_guard_tb
